// ==== hdl/lsr_readback.sv ====
// Read-only bank of line sense registers with refresh divider and control
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

// Contract
// - Loop voltage bit 6 is zero when tip above ring, one when below.
// - Loop voltage bits 5:0 hold magnitude, 1.5 V steps up to 94.5 V.
// - Loop current bit 6 is zero forward, one reverse.
// - Loop current bits 5:0 hold magnitude, 1.25 mA steps up to 78.75 mA.
// - Tip register gives 8-bit tip-to-ground code, zero means zero volts.
// - Ring register gives 8-bit ring-to-ground code on the tip scale.
// - Two battery registers each report battery rail voltage to ground.
// - First transistor register reports its current as 8-bit code.
// - Second transistor register reports its current on the same scale.
// - With extended bias enabled, transistor one and two readings exclude that current.
// - Third transistor register reports its current, 37.6 uA steps.
module lsr_readback
    import lsr_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = SAMPLE_CYCLES
)
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // Register port
    input  wire logic [lsr_pkg::ADDR_W-1:0] addr,
    input  wire logic [lsr_pkg::DATA_W-1:0] wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic      [lsr_pkg::DATA_W-1:0] rdata,
    // Loop measurements, two's complement steps
    input  wire logic [7:0]                loop_volt_diff,
    input  wire logic [7:0]                loop_current_diff,
    // Ground referred voltage codes
    input  wire logic [7:0]                tip_volt_code,
    input  wire logic [7:0]                ring_volt_code,
    input  wire logic [7:0]                battery_volt_code_a,
    input  wire logic [7:0]                battery_volt_code_b,
    // Transistor current codes
    input  wire logic [7:0]                transistor_one_current_code,
    input  wire logic [7:0]                transistor_two_current_code,
    input  wire logic [7:0]                transistor_three_current_code,
    input  wire logic [7:0]                extended_bias_current,
    // Control state seen by the line logic
    output logic                           extended_bias_enable,
    output logic                           sample_strobe
);
    import lsr_pkg::*;

    // =====================================================================
    // State
    typedef struct packed {
        logic [7:0]       loop_volt;
        logic [7:0]       loop_cur;
        logic [7:0]       tip;
        logic [7:0]       ring;
        logic [7:0]       bat_a;
        logic [7:0]       bat_b;
        logic [7:0]       q1;
        logic [7:0]       q2;
        logic [7:0]       q3;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0]       count;
        logic [DIV_W-1:0] div;
        logic             strobe;
        logic [7:0]       rdata;
    } lsr_state_t;

    lsr_state_t state_reg;
    lsr_state_t state_next;

    // =====================================================================
    // Helpers
    lsr_sense_if sense ();

    assign sense.diff[0] = loop_volt_diff;
    assign sense.diff[1] = loop_current_diff;
    assign sense.raw[0]  = transistor_one_current_code;
    assign sense.raw[1]  = transistor_two_current_code;
    assign sense.bias    = extended_bias_current;
    assign sense.bias_en = state_reg.ctrl[CTRL_BIAS_BIT];

    lsr_sign_fold u_fold
    (
        .sense (sense)
    );

    lsr_bias_comp u_comp
    (
        .sense (sense)
    );

    // =====================================================================
    // Refresh divider
    logic div_wrap;
    logic refresh;
    logic hold;

    assign div_wrap = (state_reg.div == DIV_W'(SAMPLE_DIV - 1));
    assign hold     = state_reg.ctrl[CTRL_HOLD_BIT];
    // Hold freezes the bank so software can read a coherent set
    assign refresh  = div_wrap && !hold;

    // =====================================================================
    // Field packing
    logic [7:0] loop_volt_word;
    logic [7:0] loop_cur_word;

    always_comb
    begin
        loop_volt_word                = 8'h00;
        loop_volt_word[POL_BIT]       = sense.sign[0];
        loop_volt_word[MAG_W-1:0]     = sense.mag[0];
        loop_cur_word                 = 8'h00;
        loop_cur_word[POL_BIT]        = sense.sign[1];
        loop_cur_word[MAG_W-1:0]      = sense.mag[1];
    end

    // =====================================================================
    // Register table
    localparam int unsigned N_REGS = 11;

    logic [N_REGS-1:0][ADDR_W-1:0] tbl_addr;
    logic [N_REGS-1:0][7:0]        tbl_word;
    logic [N_REGS-1:0][7:0]        tbl_mask;
    logic [N_REGS-1:0]             tbl_hit;
    logic [N_REGS-1:0][7:0]        tbl_read;
    logic                          ctrl_write;

    assign tbl_addr[0]  = ADDR_LOOP_VOLT;
    assign tbl_addr[1]  = ADDR_LOOP_CUR;
    assign tbl_addr[2]  = ADDR_TIP_VOLT;
    assign tbl_addr[3]  = ADDR_RING_VOLT;
    assign tbl_addr[4]  = ADDR_BAT_A;
    assign tbl_addr[5]  = ADDR_BAT_B;
    assign tbl_addr[6]  = ADDR_Q1_CUR;
    assign tbl_addr[7]  = ADDR_Q2_CUR;
    assign tbl_addr[8]  = ADDR_Q3_CUR;
    assign tbl_addr[9]  = ADDR_SENSE_CTRL;
    assign tbl_addr[10] = ADDR_SENSE_STAT;

    assign tbl_word[0]  = state_reg.loop_volt;
    assign tbl_word[1]  = state_reg.loop_cur;
    assign tbl_word[2]  = state_reg.tip;
    assign tbl_word[3]  = state_reg.ring;
    assign tbl_word[4]  = state_reg.bat_a;
    assign tbl_word[5]  = state_reg.bat_b;
    assign tbl_word[6]  = state_reg.q1;
    assign tbl_word[7]  = state_reg.q2;
    assign tbl_word[8]  = state_reg.q3;
    assign tbl_word[9]  = {{(8 - CTRL_W){1'b0}}, state_reg.ctrl};
    assign tbl_word[10] = state_reg.count;

    // Reserved bits read zero even if a stored word ever held them
    assign tbl_mask[0]  = 8'h7f;
    assign tbl_mask[1]  = 8'h7f;
    assign tbl_mask[2]  = 8'hff;
    assign tbl_mask[3]  = 8'hff;
    assign tbl_mask[4]  = 8'hff;
    assign tbl_mask[5]  = 8'hff;
    assign tbl_mask[6]  = 8'hff;
    assign tbl_mask[7]  = 8'hff;
    assign tbl_mask[8]  = 8'hff;
    assign tbl_mask[9]  = {{(8 - CTRL_W){1'b0}}, {CTRL_W{1'b1}}};
    assign tbl_mask[10] = 8'hff;

    genvar r;
    generate
        for (r = 0; r < N_REGS; r++)
        begin : g_reg
            assign tbl_hit[r]  = (addr == tbl_addr[r]);
            assign tbl_read[r] = tbl_hit[r] ? (tbl_word[r] & tbl_mask[r]) : 8'h00;
        end
    endgenerate

    // Sense addresses are absent here, so writes to them fall away
    assign ctrl_write = wr && (addr == ADDR_SENSE_CTRL);

    // =====================================================================
    // Read decode
    // Addresses are distinct, so one entry at most is live; unmapped read zero
    logic [7:0] read_mux;

    always_comb
    begin
        read_mux = 8'h00;
        for (int unsigned i = 0; i < N_REGS; i++)
        begin
            read_mux = read_mux | tbl_read[i];
        end
    end

    // =====================================================================
    // Next state
    always_comb
    begin
        state_next        = state_reg;
        state_next.strobe = refresh;

        if (div_wrap)
        begin
            state_next.div = '0;
        end
        else
        begin
            state_next.div = DIV_W'(state_reg.div + 1'b1);
        end

        if (refresh)
        begin
            state_next.loop_volt = loop_volt_word;
            state_next.loop_cur  = loop_cur_word;
            state_next.tip       = tip_volt_code;
            state_next.ring      = ring_volt_code;
            state_next.bat_a     = battery_volt_code_a;
            state_next.bat_b     = battery_volt_code_b;
            state_next.q1        = sense.net[0];
            state_next.q2        = sense.net[1];
            state_next.q3        = transistor_three_current_code;
            state_next.count     = 8'(state_reg.count + 1'b1);
        end

        // Only the control word takes writes; sense addresses drop them
        if (ctrl_write)
        begin
            state_next.ctrl = wdata[CTRL_W-1:0];
        end

        // Read data stands one cycle only, and reading changes nothing else
        state_next.rdata = rd ? read_mux : 8'h00;
    end

    // =====================================================================
    // Registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg.loop_volt <= RST_SENSE;
            state_reg.loop_cur  <= RST_SENSE;
            state_reg.tip       <= RST_SENSE;
            state_reg.ring      <= RST_SENSE;
            state_reg.bat_a     <= RST_SENSE;
            state_reg.bat_b     <= RST_SENSE;
            state_reg.q1        <= RST_SENSE;
            state_reg.q2        <= RST_SENSE;
            state_reg.q3        <= RST_SENSE;
            state_reg.ctrl      <= RST_CTRL;
            state_reg.count     <= RST_COUNT;
            state_reg.div       <= '0;
            state_reg.strobe    <= 1'b0;
            state_reg.rdata     <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // =====================================================================
    // Outputs
    assign rdata                = state_reg.rdata;
    assign extended_bias_enable = state_reg.ctrl[CTRL_BIAS_BIT];
    assign sample_strobe        = state_reg.strobe;

endmodule : lsr_readback

// ==== hdl/lsr_pkg.sv ====
// Package with addresses, field layout, reset values and timing of the line sense readback
package lsr_pkg;

    // =====================================================================
    // Register bus
    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned DATA_W           = 8;
    localparam logic [7:0]  ADDR_LOOP_VOLT   = 8'h4e;
    localparam logic [7:0]  ADDR_LOOP_CUR    = 8'h4f;
    localparam logic [7:0]  ADDR_TIP_VOLT    = 8'h50;
    localparam logic [7:0]  ADDR_RING_VOLT   = 8'h51;
    localparam logic [7:0]  ADDR_BAT_A       = 8'h52;
    localparam logic [7:0]  ADDR_BAT_B       = 8'h53;
    localparam logic [7:0]  ADDR_Q1_CUR      = 8'h54;
    localparam logic [7:0]  ADDR_Q2_CUR      = 8'h55;
    localparam logic [7:0]  ADDR_Q3_CUR      = 8'h56;
    localparam logic [7:0]  ADDR_SENSE_CTRL  = 8'h60;
    localparam logic [7:0]  ADDR_SENSE_STAT  = 8'h61;

    // =====================================================================
    // Field layout
    localparam int unsigned POL_BIT          = 6;
    localparam int unsigned MAG_W            = 6;
    localparam logic [5:0]  MAG_MAX          = 6'h3f;
    localparam int unsigned CTRL_BIAS_BIT    = 0;
    localparam int unsigned CTRL_HOLD_BIT    = 1;
    localparam int unsigned CTRL_W           = 2;
    localparam int unsigned DIV_W            = 16;

    // =====================================================================
    // Reset values
    localparam logic [7:0]  RST_SENSE        = 8'h00;
    localparam logic [1:0]  RST_CTRL         = 2'h0;
    localparam logic [7:0]  RST_COUNT        = 8'h00;

    // =====================================================================
    // Timing: refresh interval of the sense registers
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned SAMPLE_PERIOD_NS = 1000;
    localparam int unsigned SAMPLE_CYCLES    =
        (SAMPLE_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

endpackage : lsr_pkg

// ==== hdl/lsr_sense_if.sv ====
// Interface carrying sense values between the readback top and its helpers
`timescale 1ns/1ps
interface lsr_sense_if;
    logic [1:0][7:0] diff;
    logic [1:0]      sign;
    logic [1:0][5:0] mag;
    logic [1:0][7:0] raw;
    logic [7:0]      bias;
    logic            bias_en;
    logic [1:0][7:0] net;

    modport fold (input diff, output sign, mag);
    modport comp (input raw, bias, bias_en, output net);
    modport top  (output diff, raw, bias, bias_en, input sign, mag, net);
endinterface : lsr_sense_if

// ==== hdl/lsr_sign_fold.sv ====
// Two's complement to sign and saturated magnitude, one lane per loop quantity
`timescale 1ns/1ps
module lsr_sign_fold
    import lsr_pkg::*;
(
    // Sense lanes
    lsr_sense_if.fold sense
);
    import lsr_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lane
            logic [7:0] abs_val;
            assign abs_val = sense.diff[g][7] ? 8'(-sense.diff[g]) : sense.diff[g];
            assign sense.sign[g] = sense.diff[g][7];
            // Magnitude field holds 0..63 steps, larger readings pin at full scale
            assign sense.mag[g] = (abs_val > {2'b00, MAG_MAX}) ? MAG_MAX : abs_val[5:0];
        end
    endgenerate

endmodule : lsr_sign_fold

// ==== hdl/lsr_bias_comp.sv ====
// Removes the extended bias current from the first two transistor readings
`timescale 1ns/1ps
module lsr_bias_comp
    import lsr_pkg::*;
(
    // Sense lanes
    lsr_sense_if.comp sense
);
    import lsr_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lane
            logic [7:0] diff_val;
            assign diff_val = (sense.raw[g] > sense.bias) ? 8'(sense.raw[g] - sense.bias) : 8'h00;
            // Floor at zero so a noisy bias estimate never wraps the code
            assign sense.net[g] = sense.bias_en ? diff_val : sense.raw[g];
        end
    endgenerate

endmodule : lsr_bias_comp

// ==== sim/lsr_readback_chk.sv ====
// Concurrent checks on the ports of the line sense readback bank
`timescale 1ns/1ps
module lsr_readback_chk
#(
    parameter int unsigned SAMPLE_DIV = 2
)
(
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        nrst,
    // Register port
    input wire logic [lsr_pkg::ADDR_W-1:0]  addr,
    input wire logic [lsr_pkg::DATA_W-1:0]  wdata,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [lsr_pkg::DATA_W-1:0]  rdata,
    // Control state
    input wire logic                        extended_bias_enable,
    input wire logic                        sample_strobe
);
    import lsr_pkg::*;
    // =====================================================================
    // Hold bit shadow, refresh edge uses the value before a write lands
    logic hold_q;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            hold_q <= 1'b0;
        else if (wr && addr == ADDR_SENSE_CTRL)
            hold_q <= wdata[CTRL_HOLD_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // =====================================================================
    // Properties
    property p_rdata_idle; !rd |=> rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    property p_strobe_pulse; SAMPLE_DIV > 1 && sample_strobe |=> !sample_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("refresh strobe longer than one cycle");
    property p_bias_write;
        wr && addr == ADDR_SENSE_CTRL |=> extended_bias_enable == $past(wdata[0]);
    endproperty
    a_bias_write: assert property (p_bias_write)
        else $error("bias enable does not follow control write");
    property p_bias_stable;
        !(wr && addr == ADDR_SENSE_CTRL) |=> $stable(extended_bias_enable);
    endproperty
    a_bias_stable: assert property (p_bias_stable)
        else $error("bias enable changed without control write");
    property p_volt_top; rd && addr == ADDR_LOOP_VOLT |=> !rdata[7]; endproperty
    a_volt_top: assert property (p_volt_top)
        else $error("loop voltage bit 7 set");
    property p_cur_top; rd && addr == ADDR_LOOP_CUR |=> !rdata[7]; endproperty
    a_cur_top: assert property (p_cur_top)
        else $error("loop current bit 7 set");
    property p_unmapped; rd && addr == 8'h70 |=> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_hold; hold_q && $past(hold_q) |-> !sample_strobe; endproperty
    a_hold: assert property (p_hold)
        else $error("refresh while hold set");
endmodule : lsr_readback_chk

// ==== sim/tb_lsr_readback.sv ====
// Self-checking testbench for the line sense readback bank
`timescale 1ns/1ps
module tb_lsr_readback;
    import lsr_pkg::*;
    logic       clk = 0, nrst = 0, wr = 0, rd = 0, ebe, ss;
    logic [7:0] addr = 0, wdata = 0, rdata, lv = 0, lc = 0, tip = 0, ring = 0;
    logic [7:0] ba = 0, bb = 0, q1 = 0, q2 = 0, q3 = 0, eb = 0;
    int         error_cnt = 0;
    int         checked = 0;

    lsr_readback #(.SAMPLE_DIV(2)) DUT (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .loop_volt_diff(lv),
        .loop_current_diff(lc), .tip_volt_code(tip), .ring_volt_code(ring),
        .battery_volt_code_a(ba), .battery_volt_code_b(bb),
        .transistor_one_current_code(q1), .transistor_two_current_code(q2),
        .transistor_three_current_code(q3), .extended_bias_current(eb),
        .extended_bias_enable(ebe), .sample_strobe(ss));

    initial
    begin
        forever #25 clk = ~clk;
    end
    // =====================================================================
    // Shared tasks
    task automatic final_report;
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : reg_rd

    // Two strobes, so the second refresh saw inputs set before the first
    task automatic refresh;
        int n;
        n = 0;
        repeat (2)
        begin
            do
            begin
                @(posedge clk);
                #1;
                n++;
            end while (ss !== 1'b1 && n < 40);
        end
        if (n >= 40)
        begin
            error_cnt++;
            $display("Error at %0t: strobe got %h expected %h", $time, ss, 1'b1);
            final_report();
        end
    endtask : refresh

    function automatic logic [7:0] fold(input logic [7:0] d);
        logic [7:0] m;
        m = d[7] ? -d : d;
        return {1'b0, d[7], (m > 8'h3f) ? 6'h3f : m[5:0]};
    endfunction : fold
    // =====================================================================
    // Scenarios
    task automatic s_loop;
        logic [7:0] tbl [6] = '{8'h00, 8'h05, 8'hfb, 8'h3f, 8'h40, 8'h80};
        foreach (tbl[i])
        begin
            @(posedge clk);
            lv <= tbl[i];
            lc <= -tbl[i];
            refresh();
            reg_rd(ADDR_LOOP_VOLT, fold(tbl[i]));
            reg_rd(ADDR_LOOP_CUR, fold(-tbl[i]));
        end
    endtask : s_loop

    task automatic s_codes;
        @(posedge clk);
        {tip, ring, ba, bb} <= 32'hff5a_a53c;
        {q1, q2, q3, eb} <= 32'h8010_c320;
        refresh();
        reg_rd(ADDR_TIP_VOLT, 8'hff);
        reg_rd(ADDR_RING_VOLT, 8'h5a);
        reg_rd(ADDR_BAT_A, 8'ha5);
        reg_rd(ADDR_BAT_B, 8'h3c);
        reg_rd(ADDR_Q1_CUR, 8'h80);
        reg_rd(ADDR_Q2_CUR, 8'h10);
        reg_rd(ADDR_Q3_CUR, 8'hc3);
    endtask : s_codes

    task automatic s_bias;
        reg_wr(ADDR_SENSE_CTRL, 8'h01);
        chk({7'h00, ebe}, 8'h01);
        reg_rd(ADDR_SENSE_CTRL, 8'h01);
        refresh();
        reg_rd(ADDR_Q1_CUR, 8'h60);
        reg_rd(ADDR_Q2_CUR, 8'h00);
    endtask : s_bias

    // Frozen bank must ignore both new inputs and register writes
    task automatic s_hold;
        logic [7:0] cnt;
        reg_wr(ADDR_SENSE_CTRL, 8'h02);
        @(posedge clk);
        rd <= 1'b1;
        addr <= ADDR_SENSE_STAT;
        @(posedge clk);
        rd <= 1'b0;
        tip <= 8'h11;
        #1;
        cnt = rdata;
        reg_wr(ADDR_LOOP_VOLT, 8'haa);
        repeat (8) @(posedge clk);
        reg_rd(ADDR_SENSE_STAT, cnt);
        reg_rd(ADDR_TIP_VOLT, 8'hff);
        reg_rd(ADDR_LOOP_VOLT, fold(8'h80));
        reg_wr(ADDR_SENSE_CTRL, 8'h00);
        refresh();
        reg_rd(ADDR_TIP_VOLT, 8'h11);
        reg_rd(ADDR_Q1_CUR, 8'h80);
        reg_rd(8'h70, 8'h00);
    endtask : s_hold

    // Mid-run reset clears control, hold and the refresh count
    task automatic s_reset;
        reg_wr(ADDR_SENSE_CTRL, 8'h03);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        reg_rd(ADDR_SENSE_STAT, 8'h00);
        chk({7'h00, ebe}, 8'h00);
        reg_rd(ADDR_SENSE_CTRL, 8'h00);
        refresh();
    endtask : s_reset

    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 8'h4e; a <= 8'h56; a++)
            reg_rd(a[7:0], 8'h00);
        s_loop();
        s_codes();
        s_bias();
        s_hold();
        s_reset();
        final_report();
    end
endmodule : tb_lsr_readback

bind lsr_readback lsr_readback_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .extended_bias_enable(extended_bias_enable), .sample_strobe(sample_strobe));
